// file: logic/stxe_exec.sv
// execution unit for swap, skip, table read and xor instructions
//
// Behaviour
// - swap-to-wreg loads operand nibbles exchanged; flags untouched
// - skip-if-zero skips next instruction when operand byte is zero
// - a taken skip inserts one dummy cycle, making skips two cycles
// - copy-and-skip copies operand to wreg, skips when it is zero
// - bit-test skip skips next instruction when selected bit is zero
// - specific-page read addresses program memory by high:low pointers
// - current-page read uses low pointer inside the executing page
// - last-page read uses low pointer inside the last page, no flags
// - register xor writes wreg xor operand to wreg, updates zero flag
// - memory xor writes wreg xor operand back to memory, zero flag
// - immediate xor writes wreg xor immediate to wreg, zero flag
`default_nettype none
module stxe_exec (
  input  wire logic                            clk,
  input  wire logic                            arst_n,
  input  wire stxe_pkg::stxe_instr_t           instr,
  input  wire logic [stxe_pkg::DATA_W-1:0]     tablePointerLow,
  input  wire logic [stxe_pkg::TPH_W-1:0]      tablePointerHigh,
  input  wire logic [stxe_pkg::PROG_W-1:0]     progData,
  output var  logic [stxe_pkg::PADDR_W-1:0]    progAddr,
  output var  logic                            progRead,
  output var  logic [stxe_pkg::DATA_W-1:0]     memWrData,
  output var  logic                            memWrite,
  output var  logic [stxe_pkg::DATA_W-1:0]     workingRegister,
  output var  logic [stxe_pkg::DATA_W-1:0]     tableHighLatch,
  output var  logic                            zeroFlag,
  output var  logic                            zeroWrite,
  output var  logic                            skipDummy,
  output var  logic                            busy
);

  // complete state of the unit
  typedef struct packed {
    stxe_pkg::stxe_state_t            st;
    logic [stxe_pkg::PADDR_W-1:0]     progAddr;
    logic                             progRead;
    logic [stxe_pkg::DATA_W-1:0]      memWrData;
    logic                             memWrite;
    logic [stxe_pkg::DATA_W-1:0]      wreg;
    logic [stxe_pkg::DATA_W-1:0]      tableHigh;
    logic                             zero;
    logic                             zeroWrite;
    logic                             skipDummy;
    logic                             busy;
  } stxe_regs_t;

  stxe_regs_t r;
  stxe_regs_t next_r;

  // true when a byte is all zero; shared by the zero-byte skips and the zero flag
  function automatic logic isZero(input logic [stxe_pkg::DATA_W-1:0] v);
    isZero = (v == stxe_pkg::ZERO_BYTE);
  endfunction

  // starts a dummy cycle after a taken skip
  function automatic stxe_regs_t takeSkip(input stxe_regs_t s);
    stxe_regs_t t;
    t = s;
    t.st = stxe_pkg::STXE_DUMMY;
    t.skipDummy = 1'b1;
    t.busy = 1'b1;
    takeSkip = t;
  endfunction

  logic [stxe_pkg::DATA_W-1:0] xorMem;
  logic [stxe_pkg::DATA_W-1:0] xorImm;

  // next state: decode one instruction, run table reads and dummy cycles
  always_comb begin
    xorMem = r.wreg ^ instr.operand;
    xorImm = r.wreg ^ instr.immediate;
    next_r = r;
    next_r.memWrite = 1'b0;
    next_r.zeroWrite = 1'b0;
    next_r.progRead = 1'b0;
    next_r.skipDummy = 1'b0;
    next_r.busy = 1'b0;
    case (r.st)
      stxe_pkg::STXE_EXEC: begin
        if (instr.valid) begin
          case (instr.op)
            stxe_pkg::STXE_OP_NSWAP: begin
              next_r.wreg = {instr.operand[3:0],
                             instr.operand[7:4]};
            end
            stxe_pkg::STXE_OP_SKZ: begin
              if (isZero(instr.operand)) begin
                next_r = takeSkip(next_r);
              end
            end
            stxe_pkg::STXE_OP_CPSKZ: begin
              next_r.wreg = instr.operand;
              if (isZero(instr.operand)) begin
                next_r = takeSkip(next_r);
              end
            end
            stxe_pkg::STXE_OP_SKBZ: begin
              if (!instr.operand[instr.bitSel]) begin
                next_r = takeSkip(next_r);
              end
            end
            stxe_pkg::STXE_OP_TRDS: begin
              next_r.progAddr = {tablePointerHigh,
                                 tablePointerLow};
              next_r.progRead = 1'b1;
              next_r.busy = 1'b1;
              next_r.st = stxe_pkg::STXE_TABLE;
            end
            stxe_pkg::STXE_OP_TRDC: begin
              next_r.progAddr = {instr.pcPage,
                                 tablePointerLow};
              next_r.progRead = 1'b1;
              next_r.busy = 1'b1;
              next_r.st = stxe_pkg::STXE_TABLE;
            end
            stxe_pkg::STXE_OP_TRDL: begin
              next_r.progAddr = {stxe_pkg::LAST_PAGE,
                                 tablePointerLow};
              next_r.progRead = 1'b1;
              next_r.busy = 1'b1;
              next_r.st = stxe_pkg::STXE_TABLE;
            end
            stxe_pkg::STXE_OP_XORA: begin
              next_r.wreg = xorMem;
              next_r.zero = isZero(xorMem);
              next_r.zeroWrite = 1'b1;
            end
            stxe_pkg::STXE_OP_XMEM: begin
              next_r.memWrData = xorMem;
              next_r.memWrite = 1'b1;
              next_r.zero = isZero(xorMem);
              next_r.zeroWrite = 1'b1;
            end
            stxe_pkg::STXE_OP_XORI: begin
              next_r.wreg = xorImm;
              next_r.zero = isZero(xorImm);
              next_r.zeroWrite = 1'b1;
            end
            default: begin
              next_r.st = stxe_pkg::STXE_EXEC;
            end
          endcase
        end
      end
      stxe_pkg::STXE_TABLE: begin
        // program word returns: low byte to memory, high byte to latch
        next_r.memWrData = progData[7:0];
        next_r.memWrite = 1'b1;
        next_r.tableHigh = progData[15:8];
        next_r.st = stxe_pkg::STXE_EXEC;
      end
      stxe_pkg::STXE_DUMMY: begin
        next_r.st = stxe_pkg::STXE_EXEC;
      end
      default: begin
        next_r.st = stxe_pkg::STXE_EXEC;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r.st <= stxe_pkg::STXE_EXEC;
      r.progAddr <= stxe_pkg::RST_PADDR;
      r.progRead <= 1'b0;
      r.memWrData <= stxe_pkg::RST_BYTE;
      r.memWrite <= 1'b0;
      r.wreg <= stxe_pkg::RST_BYTE;
      r.tableHigh <= stxe_pkg::RST_BYTE;
      r.zero <= 1'b0;
      r.zeroWrite <= 1'b0;
      r.skipDummy <= 1'b0;
      r.busy <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from the state register
  always_comb begin
    progAddr = r.progAddr;
    progRead = r.progRead;
    memWrData = r.memWrData;
    memWrite = r.memWrite;
    workingRegister = r.wreg;
    tableHighLatch = r.tableHigh;
    zeroFlag = r.zero;
    zeroWrite = r.zeroWrite;
    skipDummy = r.skipDummy;
    busy = r.busy;
  end

  // instruction accepted in the execute state
  logic taken;
  assign taken = instr.valid && (r.st == stxe_pkg::STXE_EXEC);

  sequence s_skipTaken;
    taken && ((instr.op == stxe_pkg::STXE_OP_SKZ ||
               instr.op == stxe_pkg::STXE_OP_CPSKZ) &&
              isZero(instr.operand));
  endsequence

  sequence s_dummyThenExec;
    skipDummy ##1 !skipDummy && r.st == stxe_pkg::STXE_EXEC;
  endsequence

  property p_swap;
    @(posedge clk) disable iff (!arst_n)
    taken && instr.op == stxe_pkg::STXE_OP_NSWAP |=>
    workingRegister == {$past(instr.operand[3:0]),
                        $past(instr.operand[7:4])} && !zeroWrite;
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");

  property p_skz;
    @(posedge clk) disable iff (!arst_n)
    s_skipTaken |=> s_dummyThenExec;
  endproperty
  a_skz: assert property (p_skz) else $error("skip missing");

  property p_dummyLen;
    @(posedge clk) disable iff (!arst_n)
    skipDummy |=> !skipDummy;
  endproperty
  a_dummyLen: assert property (p_dummyLen)
    else $error("dummy long");

  property p_cpsk;
    @(posedge clk) disable iff (!arst_n)
    taken && instr.op == stxe_pkg::STXE_OP_CPSKZ |=>
    workingRegister == $past(instr.operand) && !zeroWrite;
  endproperty
  a_cpsk: assert property (p_cpsk) else $error("copy wrong");

  property p_bit;
    @(posedge clk) disable iff (!arst_n)
    taken && instr.op == stxe_pkg::STXE_OP_SKBZ |=>
    skipDummy == !$past(instr.operand[instr.bitSel]);
  endproperty
  a_bit: assert property (p_bit) else $error("bit skip wrong");

  property p_trds;
    @(posedge clk) disable iff (!arst_n)
    taken && instr.op == stxe_pkg::STXE_OP_TRDS |=>
    progRead && progAddr == $past({tablePointerHigh, tablePointerLow})
    ##1 memWrite && tableHighLatch == $past(progData[15:8]);
  endproperty
  a_trds: assert property (p_trds)
    else $error("table read wrong");

  property p_trdc;
    @(posedge clk) disable iff (!arst_n)
    taken && instr.op == stxe_pkg::STXE_OP_TRDC |=>
    progAddr == $past({instr.pcPage, tablePointerLow}) ##1 memWrite;
  endproperty
  a_trdc: assert property (p_trdc)
    else $error("current page wrong");

  property p_trdl;
    @(posedge clk) disable iff (!arst_n)
    taken && instr.op == stxe_pkg::STXE_OP_TRDL |=>
    progAddr[11:8] == stxe_pkg::LAST_PAGE ##1 memWrite && !zeroWrite;
  endproperty
  a_trdl: assert property (p_trdl) else $error("last page wrong");

  property p_xora;
    @(posedge clk) disable iff (!arst_n)
    taken && instr.op == stxe_pkg::STXE_OP_XORA |=>
    workingRegister == ($past(r.wreg) ^ $past(instr.operand)) &&
    zeroFlag == (workingRegister == 8'h00);
  endproperty
  a_xora: assert property (p_xora) else $error("xor wrong");

  property p_xorMem;
    @(posedge clk) disable iff (!arst_n)
    taken && instr.op == stxe_pkg::STXE_OP_XMEM |=>
    memWrite && memWrData == ($past(r.wreg) ^ $past(instr.operand)) &&
    workingRegister == $past(r.wreg);
  endproperty
  a_xorMem: assert property (p_xorMem)
    else $error("memory xor wrong");

  property p_xori;
    @(posedge clk) disable iff (!arst_n)
    taken && instr.op == stxe_pkg::STXE_OP_XORI |=>
    workingRegister == ($past(r.wreg) ^ $past(instr.immediate)) &&
    zeroWrite;
  endproperty
  a_xori: assert property (p_xori) else $error("xori wrong");

  property p_zero;
    @(posedge clk) disable iff (!arst_n)
    taken && instr.op == stxe_pkg::STXE_OP_XMEM |=>
    zeroFlag == (memWrData == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

endmodule
`default_nettype wire

// file: logic/stxe_pkg.sv
// package: operation codes, widths and reset values of the execution unit
`default_nettype none
package stxe_pkg;
  localparam int DATA_W = 8;
  localparam int PROG_W = 16;
  localparam int PADDR_W = 12;
  localparam int TPH_W = PADDR_W - DATA_W;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [PADDR_W-1:0] RST_PADDR = 12'h000;
  localparam logic [TPH_W-1:0] LAST_PAGE = 4'hf;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // operation selectors presented by the instruction decode front end
  typedef enum logic [3:0] {
    STXE_OP_NONE   = 4'h0,
    STXE_OP_NSWAP  = 4'h1,
    STXE_OP_SKZ    = 4'h2,
    STXE_OP_CPSKZ  = 4'h3,
    STXE_OP_SKBZ   = 4'h4,
    STXE_OP_TRDS   = 4'h5,
    STXE_OP_TRDC   = 4'h6,
    STXE_OP_TRDL   = 4'h7,
    STXE_OP_XORA   = 4'h8,
    STXE_OP_XMEM   = 4'h9,
    STXE_OP_XORI   = 4'ha
  } stxe_op_t;
  // one instruction handed to the unit
  typedef struct packed {
    logic                     valid;
    stxe_op_t                 op;
    logic [2:0]               bitSel;
    logic [DATA_W-1:0]        operand;
    logic [DATA_W-1:0]        immediate;
    logic [TPH_W-1:0]         pcPage;
  } stxe_instr_t;
  // execution states, one-hot
  typedef enum logic [2:0] {
    STXE_EXEC  = 3'b001,
    STXE_TABLE = 3'b010,
    STXE_DUMMY = 3'b100
  } stxe_state_t;
endpackage
`default_nettype wire

// file: test/test_skip_table_xor_exec.sv
// testbench: directed scenarios for the swap, skip, table read and xor unit
`default_nettype none
module test_skip_table_xor_exec;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  clk;
  logic                  arst_n;
  stxe_pkg::stxe_instr_t instr;
  logic [7:0]            tpLow;
  logic [3:0]            tpHigh;
  logic [15:0]           progData;
  logic [11:0]           progAddr;
  logic                  progRead;
  logic                  memWrite;
  logic                  zeroFlag;
  logic                  zeroWrite;
  logic                  skipDummy;
  logic                  busy;
  logic [7:0]            memWrData;
  logic [7:0]            workingRegister;
  logic [7:0]            tableHighLatch;
  int                    errorCnt;
  int                    nCompared;

  stxe_exec stxe_exec_i (
    .clk              (clk),
    .arst_n           (arst_n),
    .instr            (instr),
    .tablePointerLow  (tpLow),
    .tablePointerHigh (tpHigh),
    .progData         (progData),
    .progAddr         (progAddr),
    .progRead         (progRead),
    .memWrData        (memWrData),
    .memWrite         (memWrite),
    .workingRegister  (workingRegister),
    .tableHighLatch   (tableHighLatch),
    .zeroFlag         (zeroFlag),
    .zeroWrite        (zeroWrite),
    .skipDummy        (skipDummy),
    .busy             (busy)
  );

  // free-running clock, 50 ns period
  always #25 clk = ~clk;

  // compare one value and count the outcome
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errorCnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic test_done;
    $display("compared %0d, mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // present one instruction for one cycle; return in the result cycle
  task automatic send(input stxe_pkg::stxe_op_t op, input logic [7:0] opnd,
                      input logic [7:0] imm, input logic [2:0] bs);
    @(posedge clk);
    instr <= '{1'b1, op, bs, opnd, imm, 4'h5};
    @(posedge clk);
    instr.valid <= 1'b0;
    #1;
  endtask

  // zero-byte skip, taken and not taken, plus an instruction refused
  task automatic skip_byte;
    send(stxe_pkg::STXE_OP_SKZ, 8'h00, 8'h00, 3'h0);
    check(skipDummy, 1'b1);
    check(busy, 1'b1);
    check(zeroWrite, 1'b0);
    send(stxe_pkg::STXE_OP_SKZ, 8'h80, 8'h00, 3'h0);
    check(skipDummy, 1'b0);
    // xor presented during the dummy cycle must be dropped
    @(posedge clk);
    instr <= '{1'b1, stxe_pkg::STXE_OP_SKZ, 3'h0, 8'h00, 8'h00, 4'h5};
    @(posedge clk);
    instr <= '{1'b1, stxe_pkg::STXE_OP_XORI, 3'h0, 8'h00, 8'hff, 4'h5};
    @(posedge clk);
    instr.valid <= 1'b0;
    #1;
    check(zeroWrite, 1'b0);
  endtask

  // copy-and-skip and bit-test skip over every bit position
  task automatic skip_copy_bit;
    send(stxe_pkg::STXE_OP_CPSKZ, 8'h00, 8'h00, 3'h0);
    check({skipDummy, workingRegister}, 9'h100);
    send(stxe_pkg::STXE_OP_CPSKZ, 8'h80, 8'h00, 3'h0);
    check({skipDummy, workingRegister}, 9'h080);
    check(zeroWrite, 1'b0);
    for (int i = 0; i < 8; i++) begin
      send(stxe_pkg::STXE_OP_SKBZ, ~(8'h01 << i), 8'h00, 3'(i));
      check(skipDummy, 1'b1);
      send(stxe_pkg::STXE_OP_SKBZ, 8'h01 << i, 8'h00, 3'(i));
      check({skipDummy, zeroWrite}, 2'b00);
    end
  endtask

  // one table read: address, then low byte to memory, high byte to latch
  task automatic tbl(input stxe_pkg::stxe_op_t op, input logic [11:0] adr,
                     input logic [15:0] word);
    @(posedge clk);
    progData <= word;
    send(op, 8'h00, 8'h00, 3'h0);
    check({progRead, progAddr}, {1'b1, adr});
    @(posedge clk);
    #1;
    check({memWrite, memWrData}, {1'b1, word[7:0]});
    check(tableHighLatch, word[15:8]);
    check(zeroWrite, 1'b0);
  endtask

  // xor variants, zero flag both ways, then swap leaving flags alone
  task automatic xor_swap;
    send(stxe_pkg::STXE_OP_CPSKZ, 8'h5a, 8'h00, 3'h0);
    send(stxe_pkg::STXE_OP_XORI, 8'h00, 8'h0f, 3'h0);
    check({zeroWrite, zeroFlag, workingRegister}, 10'h255);
    send(stxe_pkg::STXE_OP_XMEM, 8'h55, 8'h00, 3'h0);
    check({memWrite, memWrData}, 9'h100);
    check({zeroWrite, zeroFlag, workingRegister}, 10'h355);
    send(stxe_pkg::STXE_OP_XORA, 8'h3c, 8'h00, 3'h0);
    check({zeroWrite, zeroFlag, workingRegister}, 10'h269);
    check(memWrite, 1'b0);
    send(stxe_pkg::STXE_OP_XORA, 8'h69, 8'h00, 3'h0);
    check({zeroWrite, workingRegister}, 9'h100);
    check(zeroFlag, 1'b1);
    send(stxe_pkg::STXE_OP_XMEM, 8'h0f, 8'h00, 3'h0);
    check({memWrite, memWrData, zeroFlag}, 10'h21e);
    send(stxe_pkg::STXE_OP_XORI, 8'h00, 8'h00, 3'h0);
    check({zeroWrite, workingRegister}, 9'h100);
    check(zeroFlag, 1'b1);
    send(stxe_pkg::STXE_OP_NSWAP, 8'h3c, 8'h00, 3'h0);
    check(workingRegister, 8'hc3);
    check({zeroWrite, zeroFlag, memWrite}, 3'b010);
  endtask

  // hang guard
  initial begin
    repeat (5000) @(posedge clk);
    errorCnt++;
    test_done();
  end

  // reset, then the scenarios in turn
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    instr = '0;
    tpLow = 8'h3e;
    tpHigh = 4'ha;
    progData = 16'h0000;
    errorCnt = 0;
    nCompared = 0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    check({workingRegister, tableHighLatch}, 16'h0000);
    check({zeroFlag, busy}, 2'b00);
    skip_byte();
    skip_copy_bit();
    tbl(stxe_pkg::STXE_OP_TRDS, 12'ha3e, 16'hb7c4);
    tbl(stxe_pkg::STXE_OP_TRDC, 12'h53e, 16'h19e2);
    tbl(stxe_pkg::STXE_OP_TRDL, 12'hf3e, 16'hd06b);
    xor_swap();
    test_done();
  end
endmodule
`default_nettype wire
